//--- core/sscf_top.sv
// serial port status/control flags with a slave shift engine and axi4-lite registers
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module sscf_top
   import sscf_pkg::*;
#(
   parameter int unsigned WORD_W = 16
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [sscf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [sscf_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [sscf_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [sscf_pkg::DATA_W-1:0]    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      device_idle,
   input  wire logic                      serial_clock_pin,
   input  wire logic                      serial_in_pin,
   input  wire logic                      slave_select_pin_n,
   output logic                           serial_out_pin,
   output logic                           serial_out_pin_oe,
   output logic                           serial_pins_owned,
   output logic                           irq
);
   import sscf_pkg::*;

   logic              port_enable_q;
   logic              halt_in_idle_q;
   logic              rx_overflow_q;
   logic              tx_full_q;
   logic              rx_full_q;
   logic [WORD_W-1:0] tx_hold_q;
   logic [WORD_W-1:0] rx_hold_q;
   logic [WORD_W-1:0] shift_q;
   logic [4:0]        bit_cnt_q;
   logic              loaded_q;
   logic              sck_prev_q;
   logic [IRQ_W-1:0]  irq_stat_q;
   logic [IRQ_W-1:0]  irq_mask_q;
   logic              aw_held_q;
   logic              w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [15:0]       w_data_q;
   logic [3:0]        w_strb_q;

   logic sck_s;
   logic sdi_s;
   logic ss_n_s;
   logic running;
   logic sck_rise;
   logic sck_fall;
   logic do_write;
   logic do_read;
   logic wr_ctrl;
   logic wr_buf;
   logic rd_buf;
   logic rd_irq;
   logic load_shift;
   logic word_done;
   logic rx_store;
   logic rx_drop;
   logic [15:0] status_ctrl;
   logic [15:0] rx_word16;
   logic [DATA_W-1:0] rd_word;
   logic [1:0]  rd_resp;

   sscf_sync #(.RESET_VAL(1'b0)) u_sync_sck (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (serial_clock_pin),
      .level_q (sck_s)
   );
   sscf_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (serial_in_pin),
      .level_q (sdi_s)
   );
   sscf_sync #(.RESET_VAL(1'b1)) u_sync_ss (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (slave_select_pin_n),
      .level_q (ss_n_s)
   );

   // engine runs only when enabled and not halted by idle
   assign running    = port_enable_q && !(halt_in_idle_q && device_idle);
   assign sck_rise   = running && !ss_n_s && sck_s && !sck_prev_q;
   assign sck_fall   = running && !ss_n_s && !sck_s && sck_prev_q;
   // wait for select, else the word is consumed while the shifter is held idle
   assign load_shift = running && !ss_n_s && tx_full_q && !loaded_q && bit_cnt_q == 5'h00;
   assign word_done  = sck_rise && bit_cnt_q == 5'(WORD_W - 1);
   assign rx_store   = word_done && !rx_full_q;
   assign rx_drop    = word_done && rx_full_q;

   // register bus decode
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   assign do_read  = s_axi_arvalid && s_axi_arready;
   assign wr_ctrl  = do_write && aw_addr_q == OFS_STATUS_CTRL;
   assign wr_buf   = do_write && aw_addr_q == OFS_SHARED_BUF;
   assign rd_buf   = do_read && s_axi_araddr == OFS_SHARED_BUF;
   assign rd_irq   = do_read && s_axi_araddr == OFS_IRQ_STATUS;

   // unused positions tie to zero
   always_comb begin
      status_ctrl                   = 16'h0000;
      status_ctrl[BIT_PORT_ENABLE]  = port_enable_q;
      status_ctrl[BIT_HALT_IN_IDLE] = halt_in_idle_q;
      status_ctrl[BIT_RX_OVERFLOW]  = rx_overflow_q;
      status_ctrl[BIT_TX_FULL]      = tx_full_q;
      status_ctrl[BIT_RX_FULL]      = rx_full_q;
   end

   always_comb begin
      rx_word16         = 16'h0000;
      rx_word16[WORD_W-1:0] = rx_hold_q;
   end

   // write channel capture; address and data may come in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= 16'h0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == OFS_STATUS_CTRL || aw_addr_q == OFS_SHARED_BUF ||
                             aw_addr_q == OFS_IRQ_STATUS || aw_addr_q == OFS_IRQ_MASK) ?
                            RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read data decode; unmapped offsets answer zero with a decode error
   always_comb begin
      rd_word = '0;
      rd_resp = RESP_OKAY;
      case (s_axi_araddr)
         OFS_STATUS_CTRL: rd_word = {16'h0000, status_ctrl};
         OFS_SHARED_BUF:  rd_word = {16'h0000, rx_word16};
         OFS_IRQ_STATUS:  rd_word = {29'h0000000, irq_stat_q};
         OFS_IRQ_MASK:    rd_word = {29'h0000000, irq_mask_q};
         default:         rd_resp = RESP_DECERR;
      endcase
   end

   // read channel; one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !do_read;
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_resp;
            s_axi_rdata  <= rd_word;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_enable_q  <= STATUS_CTRL_RESET[BIT_PORT_ENABLE];
         halt_in_idle_q <= STATUS_CTRL_RESET[BIT_HALT_IN_IDLE];
      end else if (do_write) begin
         if (aw_addr_q == OFS_STATUS_CTRL && w_strb_q[1]) begin
            port_enable_q  <= w_data_q[BIT_PORT_ENABLE];
            halt_in_idle_q <= w_data_q[BIT_HALT_IN_IDLE];
         end
      end
   end

   // interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (do_write && aw_addr_q == OFS_IRQ_MASK && w_strb_q[0]) begin
         irq_mask_q <= w_data_q[IRQ_W-1:0];
      end
   end

   // overflow: hardware sets, software writes zero to clear; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_overflow_q <= STATUS_CTRL_RESET[BIT_RX_OVERFLOW];
      end else if (rx_drop) begin
         rx_overflow_q <= 1'b1;
      end else if (wr_ctrl && w_strb_q[0] && !w_data_q[BIT_RX_OVERFLOW]) begin
         rx_overflow_q <= 1'b0;
      end
   end

   // transmit holding register and its full flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_hold_q <= '0;
         tx_full_q <= STATUS_CTRL_RESET[BIT_TX_FULL];
      end else if (wr_buf) begin
         tx_hold_q <= w_data_q[WORD_W-1:0];
         tx_full_q <= 1'b1;
      end else if (load_shift) begin
         tx_full_q <= 1'b0;
      end
   end

   // receive holding data; a dropped word never touches it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_hold_q <= '0;
      end else if (rx_store) begin
         rx_hold_q <= {shift_q[WORD_W-2:0], sdi_s};
      end
   end

   // receive full flag; a new word wins over a read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_full_q <= STATUS_CTRL_RESET[BIT_RX_FULL];
      end else if (rx_store) begin
         rx_full_q <= 1'b1;
      end else if (rd_buf) begin
         rx_full_q <= 1'b0;
      end
   end

   // edge history follows the pin even while halted, so waking gives no stale edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
      end
   end

   // shift engine; disabling drops a word in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q    <= '0;
         bit_cnt_q  <= 5'h00;
         loaded_q   <= 1'b0;
      end else if (!port_enable_q || ss_n_s) begin
         bit_cnt_q  <= 5'h00;
         loaded_q   <= 1'b0;
      end else if (running) begin
         if (load_shift) begin
            shift_q  <= tx_hold_q;
            loaded_q <= 1'b1;
         end else if (sck_rise) begin
            shift_q <= {shift_q[WORD_W-2:0], sdi_s};
            if (word_done) begin
               bit_cnt_q <= 5'h00;
               loaded_q  <= 1'b0;
            end else begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
         end
      end
   end

   // pins: out data changes on falling clock, driven only when owned and selected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_pin    <= 1'b0;
         serial_out_pin_oe <= 1'b0;
         serial_pins_owned <= 1'b0;
      end else begin
         serial_pins_owned <= port_enable_q;
         serial_out_pin_oe <= port_enable_q && !ss_n_s;
         if (load_shift) begin
            serial_out_pin <= tx_hold_q[WORD_W-1];
         end else if (sck_fall) begin
            serial_out_pin <= shift_q[WORD_W-1];
         end
      end
   end

   // sticky events, cleared by reading; a new event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q[IRQ_RX_FULL]  <= rx_store || (irq_stat_q[IRQ_RX_FULL] && !rd_irq);
         irq_stat_q[IRQ_TX_EMPTY] <= load_shift || (irq_stat_q[IRQ_TX_EMPTY] && !rd_irq);
         irq_stat_q[IRQ_OVERFLOW] <= rx_drop || (irq_stat_q[IRQ_OVERFLOW] && !rd_irq);
      end
   end

   // level output one cycle behind the masked status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule

//--- core/sscf_pkg.sv
// constants for the serial port status and control block
package sscf_pkg;
   localparam int unsigned ADDR_W            = 8;
   localparam int unsigned DATA_W            = 32;
   localparam logic [7:0]  OFS_STATUS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_SHARED_BUF    = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK      = 8'h0c;
   localparam int unsigned BIT_PORT_ENABLE   = 15;
   localparam int unsigned BIT_HALT_IN_IDLE  = 13;
   localparam int unsigned BIT_RX_OVERFLOW   = 6;
   localparam int unsigned BIT_TX_FULL       = 1;
   localparam int unsigned BIT_RX_FULL       = 0;
   localparam int unsigned IRQ_RX_FULL       = 0;
   localparam int unsigned IRQ_TX_EMPTY      = 1;
   localparam int unsigned IRQ_OVERFLOW      = 2;
   localparam int unsigned IRQ_W             = 3;
   localparam logic [15:0] STATUS_CTRL_RESET = 16'h0000;
   localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_DECERR       = 2'h3;
   localparam int unsigned SYNC_STAGES       = 3;
endpackage

//--- core/sscf_sync.sv
// three-flop synchroniser with agreement filter for one pin
`timescale 1ns/1ns
module sscf_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   output logic      level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // change only counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_q <= RESET_VAL;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
endmodule

//--- tb/sscf_top_checker.sv
// bus and pin assertions for the serial port status block
`timescale 1ns/1ns
module sscf_checker
   import sscf_pkg::*;
#(
   parameter int unsigned WORD_W = 16
) (
   input wire logic                          aclk,
   input wire logic                          aresetn,
   input wire logic                          s_axi_awvalid,
   input wire logic                          s_axi_awready,
   input wire logic                          s_axi_wvalid,
   input wire logic                          s_axi_wready,
   input wire logic [1:0]                    s_axi_bresp,
   input wire logic                          s_axi_bvalid,
   input wire logic [sscf_pkg::ADDR_W-1:0]   s_axi_araddr,
   input wire logic                          s_axi_arvalid,
   input wire logic                          s_axi_arready,
   input wire logic [sscf_pkg::DATA_W-1:0]   s_axi_rdata,
   input wire logic [1:0]                    s_axi_rresp,
   input wire logic                          s_axi_rvalid,
   input wire logic                          slave_select_pin_n,
   input wire logic                          serial_out_pin_oe,
   input wire logic                          serial_pins_owned
);
   logic [7:0] ar_q;
   logic       mapped;
   // remember the read address so the answer can be judged
   always_ff @(posedge aclk) begin
      if (!aresetn) ar_q <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   assign mapped = ar_q inside {OFS_STATUS_CTRL, OFS_SHARED_BUF, OFS_IRQ_STATUS, OFS_IRQ_MASK};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_STAT_RSVD: assert property (s_axi_rvalid && ar_q == OFS_STATUS_CTRL |-> (s_axi_rdata & 32'hffff5fbc) == 32'h0)
      else $error("status reserved bits not zero");
   AST_BUF_WIDTH: assert property (s_axi_rvalid && ar_q == OFS_SHARED_BUF |-> (s_axi_rdata >> WORD_W) == 32'h0)
      else $error("buffer read wider than word");
   AST_UNMAPPED: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_MAPPED_OK: assert property (s_axi_rvalid && mapped |-> s_axi_rresp == RESP_OKAY)
      else $error("mapped read refused");
   AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_WRITE_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   AST_NO_AR_IN_R: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during answer");
   AST_NO_AW_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   AST_OE_OWNED: assert property (serial_out_pin_oe |-> serial_pins_owned || $past(serial_pins_owned))
      else $error("data out driven while port off");
   AST_OE_DESELECT: assert property (slave_select_pin_n [*7] |-> !serial_out_pin_oe)
      else $error("data out driven while not selected");
   cover property (s_axi_rvalid && ar_q == OFS_SHARED_BUF);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
   cover property ($rose(serial_out_pin_oe));
endmodule
bind sscf_top sscf_checker #(.WORD_W(WORD_W)) u_sscf_checker (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .slave_select_pin_n(slave_select_pin_n), .serial_out_pin_oe(serial_out_pin_oe),
   .serial_pins_owned(serial_pins_owned));

//--- tb/sscf_link_master.sv
// four-wire link master model, clock idle low outside frames
`timescale 1ns/1ns
module sscf_link_master (
   output logic     sck,
   output logic     mosi,
   output logic     ss_n,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      mosi = 1'b1;
      ss_n = 1'b1;
   end
   // odd start offset keeps link edges off the block clock edges
   task automatic frame(input logic [15:0] m, output logic [15:0] s);
      #7 ss_n = 1'b0;
      #320;
      for (int i = 15; i >= 0; i--) begin
         mosi = m[i];
         #80 sck = 1'b1;
         // sample late in the high phase, device shifts on falling
         #70 s[i] = miso;
         #10 sck = 1'b0;
      end
      #320 ss_n = 1'b1;
      mosi = ~mosi;
   endtask
endmodule

//--- tb/sscf_top_tb.sv
// register and link tests for the serial port status block
`timescale 1ns/1ns
module sscf_top_tb;
   import sscf_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, device_idle = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_d;
   logic [1:0]  bresp, rresp, rsp;
   logic awready, wready, bvalid, arready, rvalid, sdo, sdo_oe, owned, irq, sck, mosi, ss_n;
   logic [15:0] sw;
   int   error_cnt = 0, compares = 0;
   always #10 aclk = ~aclk;
   sscf_top u_sscf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .device_idle(device_idle),
      .serial_clock_pin(sck), .serial_in_pin(mosi), .slave_select_pin_n(ss_n), .serial_out_pin(sdo),
      .serial_out_pin_oe(sdo_oe), .serial_pins_owned(owned), .irq(irq));
   // undriven data out shows the inverse, never a stale level
   sscf_link_master u_sscf_link_master (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(sdo_oe ? sdo : ~sdo));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tmo;
      error_cnt++;
      $display("[ERR] bus wait exp 1 got 0");
      tally_and_finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      if (i == 40) tmo;
      rsp = bresp; bready <= 0;
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a);
      int i;
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      if (i == 40) tmo;
      rd_d = rdata; rsp = rresp; rready <= 0;
      @(posedge aclk);
   endtask
   task lf(input logic [15:0] m);
      u_sscf_link_master.frame(m, sw);
      repeat (8) @(posedge aclk);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(OFS_STATUS_CTRL); chk("stat_rst", 32'h0, rd_d);
      rd(OFS_IRQ_MASK); chk("mask_rst", 32'h0, rd_d);
      wr(OFS_STATUS_CTRL, 32'hffffffff); rd(OFS_STATUS_CTRL); chk("stat_ones", 32'ha000, rd_d);
      chk("owned_on", 32'h1, 32'(owned));
      wr(OFS_STATUS_CTRL, 32'h0); repeat (2) @(posedge aclk); chk("owned_off", 32'h0, 32'(owned));
      wr(OFS_SHARED_BUF, 32'h1234); lf(16'h0f0f); rd(OFS_STATUS_CTRL); chk("stat_off", 32'h2, rd_d);
      $display("test disabled done");
      wr(OFS_IRQ_MASK, 32'h7); wr(OFS_STATUS_CTRL, 32'ha000);
      lf(16'h3c5a); chk("tx_word", 32'h1234, 32'(sw));
      rd(OFS_STATUS_CTRL); chk("stat_rx", 32'ha001, rd_d);
      chk("irq_on", 32'h1, 32'(irq));
      rd(OFS_IRQ_STATUS); chk("irq_stat", 32'h3, rd_d);
      repeat (2) @(posedge aclk); chk("irq_off", 32'h0, 32'(irq));
      rd(OFS_SHARED_BUF); chk("rx_word", 32'h3c5a, rd_d);
      rd(OFS_STATUS_CTRL); chk("stat_read", 32'ha000, rd_d);
      $display("test transfer done");
      device_idle <= 1; lf(16'h5555); rd(OFS_STATUS_CTRL); chk("stat_halt", 32'ha000, rd_d);
      device_idle <= 0;
      $display("test halt done");
      lf(16'h1111); lf(16'h2222); rd(OFS_STATUS_CTRL); chk("stat_ovf", 32'ha041, rd_d);
      rd(OFS_IRQ_STATUS); chk("irq_ovf", 32'h5, rd_d);
      rd(OFS_SHARED_BUF); chk("ovf_word", 32'h1111, rd_d);
      rd(OFS_STATUS_CTRL); chk("ovf_kept", 32'ha040, rd_d);
      wr(OFS_STATUS_CTRL, 32'ha000); rd(OFS_STATUS_CTRL); chk("ovf_clr", 32'ha000, rd_d);
      $display("test overflow done");
      wr(OFS_IRQ_MASK, 32'h2); lf(16'h4242); chk("irq_masked", 32'h0, 32'(irq));
      rd(OFS_IRQ_STATUS); chk("irq_stat_m", 32'h1, rd_d);
      rd(OFS_SHARED_BUF); chk("rx_word2", 32'h4242, rd_d);
      rd(8'h10); chk("unm_rresp", 32'h3, 32'(rsp)); chk("unm_rdata", 32'h0, rd_d);
      wr(8'h10, 32'h1); chk("unm_bresp", 32'h3, 32'(rsp));
      $display("test mask done");
      tally_and_finish;
   end
endmodule
